// file: hdl/hwwd_defs.vh
// Constants for the halt, wake-up and watchdog block
`ifndef HWWD_DEFS_VH
`define HWWD_DEFS_VH
// APB byte offsets
`define HWWD_ADDR_WDCTRL 8'h00
`define HWWD_ADDR_RSTFLAGS 8'h04
`define HWWD_ADDR_SYSCLK 8'h08
`define HWWD_ADDR_STATUS 8'h0C
`define HWWD_ADDR_WAKEEN 8'h10
`define HWWD_ADDR_CORE 8'h14
// Watchdog control fields and reset value
`define HWWD_WDCTRL_RESET 8'h53
`define HWWD_KEY_MSB 7
`define HWWD_KEY_LSB 3
`define HWWD_SEL_MSB 2
`define HWWD_SEL_LSB 0
`define HWWD_KEY_ENABLE 5'h0A
`define HWWD_KEY_DISABLE 5'h15
// Reset flag register bit
`define HWWD_RF_KEY 0
// System clock control bits
`define HWWD_SYSCLK_SUB 0
`define HWWD_SYSCLK_HS 1
// Status register bits
`define HWWD_ST_PWRDN 0
`define HWWD_ST_TMO 1
// Core register bits
`define HWWD_CORE_IEN 0
`define HWWD_CORE_STKFULL 1
// Operating mode codes
`define HWWD_MODE_FAST 3'h0
`define HWWD_MODE_IDLE0 3'h1
`define HWWD_MODE_IDLE1 3'h2
`define HWWD_MODE_IDLE2 3'h3
`define HWWD_MODE_SLEEP 3'h4
// Software reset delay, in ns, and derived clock count at 25 MHz
`define HWWD_SRESET_NS 1000
`define HWWD_CLK_NS 40
`define HWWD_SRESET_CYC ((`HWWD_SRESET_NS + `HWWD_CLK_NS - 1) / `HWWD_CLK_NS)
`endif

// file: hdl/hwwd_sync.v
// Two-stage synchroniser for a bus of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module hwwd_sync #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1_reg;
    // Only the second stage is visible outside
    always @(posedge clk)
    begin
        if (rst)
        begin
            stage1_reg <= {WIDTH{1'b1}};
            syncOut <= {WIDTH{1'b1}};
        end
        else
        begin
            stage1_reg <= asyncIn;
            syncOut <= stage1_reg;
        end
    end
endmodule // hwwd_sync
`default_nettype wire

// file: hdl/hwwd_wdt_counter.v
// Watchdog counter running on the slow RC tick
`timescale 1ns/1ns
`default_nettype none
`include "hwwd_defs.vh"
module hwwd_wdt_counter #(
    parameter CW = 18
) (
    input wire clk,
    input wire rst,
    input wire tick,
    input wire run,
    input wire clear,
    input wire [2:0] periodSel,
    output reg overflow
);
    reg [CW-1:0] count_reg;
    wire [4:0] expo;

    // Period exponent per select code
    function [4:0] selToExp;
        input [2:0] s;
        begin
            case (s)
                3'h0: selToExp = 5'd8;
                3'h1: selToExp = 5'd10;
                3'h2: selToExp = 5'd12;
                3'h3: selToExp = 5'd14;
                3'h4: selToExp = 5'd15;
                3'h5: selToExp = 5'd16;
                3'h6: selToExp = 5'd17;
                default: selToExp = 5'd18;
            endcase
        end
    endfunction

    assign expo = selToExp(periodSel);

    // Count slow ticks; overflow pulses when the selected count is reached
    always @(posedge clk)
    begin
        overflow <= 1'b0;
        if (rst || clear)
            count_reg <= {CW{1'b0}};
        else if (run && tick)
        begin
            if (count_reg == (({{(CW-1){1'b0}}, 1'b1} << expo) - 1'b1))
            begin
                count_reg <= {CW{1'b0}};
                overflow <= 1'b1;
            end
            else
                count_reg <= count_reg + 1'b1;
        end
    end
endmodule // hwwd_wdt_counter
`default_nettype wire

// file: hdl/hwwd_top.v
// Halt, wake-up and watchdog control with an APB register slave
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "hwwd_defs.vh"
// Summary of operation
// - Halt, hs off sub on: IDLE0
// - Halt, both keep bits: IDLE1
// - Halt, hs on sub off: IDLE2
// - Power-down holds memory, registers, ports
// - Power-down sets powerdown flag, clears timeout
// - Halt clears watchdog; runs only if enabled
// - Wake on port edge, interrupt, overflow
// - Powerdown flag cleared by power-up, clear
// - Overflow asleep: timeout flag, PC/SP reset
// - Per-pin wake enables; resume after halt
// - Disabled or stack-full: resume, stay pending
// - Enabled with free stack: take interrupt
// - Already-pending interrupt never wakes
// - Sleep wake waits for RC stable
// - Slow RC count, period select codes
// - Key enables, disables, else delayed reset
// - Bad key reset sets key flag
// - Key flag cleared only by software or power-up
// - Key resets enabled, period 011
// - Awake overflow: full reset, timeout flag
// - Counter cleared by key, clear, halt
// - Halt, both zero: SLEEP, hs and sub clocks off
module hwwd_top #(
    parameter PORTW = 8
) (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire haltInstr,
    input wire clearWatchdogInstruction,
    input wire slowRcTick,
    input wire internalRcStableFlag,
    input wire [PORTW-1:0] portAPins,
    input wire intRequest,
    output reg [2:0] opMode,
    output reg hsClockEn,
    output reg subClockEn,
    output reg slowRcEn,
    output reg cpuRun,
    output reg wakeResume,
    output reg wakeTakeInt,
    output reg pcSpReset,
    output reg deviceReset
);
    // ----------------------------------------
    // Operating states
    // ----------------------------------------
    localparam ST_RUN = 2'd0;
    localparam ST_DOWN = 2'd1;
    localparam ST_WAITRC = 2'd2;
    localparam integer SRESET_INT = `HWWD_SRESET_CYC;
    localparam [15:0] SRESET_CYC = SRESET_INT[15:0];

    reg [1:0] state_reg;
    reg [7:0] wdCtrl_reg;
    reg [7:0] rstFlags_reg;
    reg [1:0] sysClockCtrl_reg;
    reg powerdownFlag_reg;
    reg timeoutFlag_reg;
    reg [PORTW-1:0] portaWakeEnable_reg;
    reg intEnable_reg;
    reg stackFull_reg;
    reg [PORTW-1:0] portPrev_reg;
    reg intMasked_reg;
    reg keyResetPend_reg;
    reg [15:0] sresetCnt_reg;
    reg wdClear;
    wire [PORTW-1:0] portSync;
    wire [1:0] ctlSync;
    wire wdOverflow;
    wire [4:0] wdKey;
    wire wdEnabled;
    wire keyBad;
    wire wrAccess;
    wire portWake;
    wire intEdge;

    assign wdKey = wdCtrl_reg[`HWWD_KEY_MSB:`HWWD_KEY_LSB];
    assign wdEnabled = (wdKey == `HWWD_KEY_ENABLE);
    assign keyBad = !wdEnabled && (wdKey != `HWWD_KEY_DISABLE);
    assign wrAccess = psel && penable && pwrite;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    hwwd_sync #(.WIDTH(PORTW)) uPortSync (
        .clk(clk),
        .rst(rst),
        .asyncIn(portAPins),
        .syncOut(portSync)
    );

    hwwd_sync #(.WIDTH(2)) uCtlSync (
        .clk(clk),
        .rst(rst),
        .asyncIn({internalRcStableFlag, slowRcTick}),
        .syncOut(ctlSync)
    );

    // ----------------------------------------
    // Watchdog counter
    // ----------------------------------------
    // Clear on key fault, clear instruction or halt
    always @*
    begin
        wdClear = clearWatchdogInstruction || keyBad || (haltInstr && state_reg == ST_RUN);
    end

    // Counts slow RC ticks with selected period
    hwwd_wdt_counter #(.CW(18)) uCounter (
        .clk(clk),
        .rst(rst),
        .tick(ctlSync[0]),
        .run(wdEnabled),
        .clear(wdClear),
        .periodSel(wdCtrl_reg[`HWWD_SEL_MSB:`HWWD_SEL_LSB]),
        .overflow(wdOverflow)
    );

    // Tick arrives as a level from the sync; treat each high cycle as one tick
    // (the slow RC tick is expected as a one-cycle-wide strobe per period).

    // ----------------------------------------
    // Wake sources
    // ----------------------------------------
    // Falling edge on an enabled pin
    assign portWake = |(portPrev_reg & ~portSync & portaWakeEnable_reg);
    // A request already high at halt is masked
    assign intEdge = intRequest && !intMasked_reg;

    always @(posedge clk)
    begin
        if (rst)
        begin
            portPrev_reg <= {PORTW{1'b1}};
        end
        else
        begin
            portPrev_reg <= portSync;
        end
    end

    // ----------------------------------------
    // Power-down sequencer
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= ST_RUN;
            opMode <= `HWWD_MODE_FAST;
            hsClockEn <= 1'b1;
            subClockEn <= 1'b1;
            slowRcEn <= 1'b1;
            cpuRun <= 1'b1;
            wakeResume <= 1'b0;
            wakeTakeInt <= 1'b0;
            pcSpReset <= 1'b0;
            intMasked_reg <= 1'b0;
            powerdownFlag_reg <= 1'b0;
            timeoutFlag_reg <= 1'b0;
        end
        else
        begin
            wakeResume <= 1'b0;
            wakeTakeInt <= 1'b0;
            pcSpReset <= 1'b0;
            if (clearWatchdogInstruction)
                powerdownFlag_reg <= 1'b0;
            case (state_reg)
                ST_RUN:
                begin
                    if (wdOverflow)
                        timeoutFlag_reg <= 1'b1;
                    else if (haltInstr)
                    begin
                        // CPU stops and clocks follow sysClockCtrl_reg; powerdown and timeout flags and interrupt mask update, other registers hold
                        state_reg <= ST_DOWN;
                        cpuRun <= 1'b0;
                        powerdownFlag_reg <= 1'b1;
                        timeoutFlag_reg <= 1'b0;
                        intMasked_reg <= intRequest;
                        // Slow RC runs in sleep only if enabled
                        slowRcEn <= wdEnabled || sysClockCtrl_reg[`HWWD_SYSCLK_SUB];
                        hsClockEn <= sysClockCtrl_reg[`HWWD_SYSCLK_HS];
                        subClockEn <= sysClockCtrl_reg[`HWWD_SYSCLK_SUB];
                        case (sysClockCtrl_reg)
                            2'b01: opMode <= `HWWD_MODE_IDLE0;
                            2'b11: opMode <= `HWWD_MODE_IDLE1;
                            2'b10: opMode <= `HWWD_MODE_IDLE2;
                            default: opMode <= `HWWD_MODE_SLEEP;
                        endcase
                    end
                end
                ST_DOWN:
                begin
                    if (!intRequest)
                        intMasked_reg <= 1'b0;
                    if (wdOverflow || portWake || intEdge)
                    begin
                        hsClockEn <= 1'b1;
                        subClockEn <= 1'b1;
                        slowRcEn <= 1'b1;
                        // Sleep wake waits for RC stable
                        if (opMode == `HWWD_MODE_SLEEP)
                            state_reg <= ST_WAITRC;
                        else
                        begin
                            state_reg <= ST_RUN;
                            opMode <= `HWWD_MODE_FAST;
                            cpuRun <= 1'b1;
                        end
                        // Overflow asleep: flag and PC/SP reset
                        if (wdOverflow)
                        begin
                            timeoutFlag_reg <= 1'b1;
                            pcSpReset <= 1'b1;
                        end
                        // Enabled with free stack services it
                        else if (intEdge && intEnable_reg && !stackFull_reg)
                            wakeTakeInt <= 1'b1;
                        // Otherwise resume; request stays pending at source
                        else
                            wakeResume <= 1'b1;
                    end
                end
                ST_WAITRC:
                begin
                    if (ctlSync[1])
                    begin
                        state_reg <= ST_RUN;
                        opMode <= `HWWD_MODE_FAST;
                        cpuRun <= 1'b1;
                    end
                end
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    // ----------------------------------------
    // Device reset generation
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (rst)
        begin
            keyResetPend_reg <= 1'b0;
            sresetCnt_reg <= 16'h0000;
            deviceReset <= 1'b0;
        end
        else
        begin
            // Awake overflow gives a full reset pulse
            deviceReset <= wdOverflow && state_reg == ST_RUN;
            // Bad key resets after the delay
            if (keyBad && !keyResetPend_reg)
            begin
                keyResetPend_reg <= 1'b1;
                sresetCnt_reg <= 16'h0001; // Detect cycle counts, so delay is exact
            end
            else if (keyResetPend_reg)
            begin
                if (sresetCnt_reg == SRESET_CYC - 16'h0001)
                begin
                    keyResetPend_reg <= 1'b0;
                    deviceReset <= 1'b1;
                end
                else
                    sresetCnt_reg <= sresetCnt_reg + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // APB registers
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (rst)
        begin
            wdCtrl_reg <= `HWWD_WDCTRL_RESET;
            rstFlags_reg <= 8'h00;
            sysClockCtrl_reg <= 2'b00;
            portaWakeEnable_reg <= {PORTW{1'b0}};
            intEnable_reg <= 1'b0;
            stackFull_reg <= 1'b0;
        end
        else
        begin
            if (wrAccess)
            begin
                case (paddr)
                    `HWWD_ADDR_WDCTRL: wdCtrl_reg <= pwdata[7:0];
                    // Software may only clear the key flag
                    `HWWD_ADDR_RSTFLAGS: rstFlags_reg[`HWWD_RF_KEY] <=
                        rstFlags_reg[`HWWD_RF_KEY] & pwdata[`HWWD_RF_KEY];
                    `HWWD_ADDR_SYSCLK: sysClockCtrl_reg <= pwdata[1:0];
                    `HWWD_ADDR_WAKEEN: portaWakeEnable_reg <= pwdata[PORTW-1:0];
                    `HWWD_ADDR_CORE:
                    begin
                        intEnable_reg <= pwdata[`HWWD_CORE_IEN];
                        stackFull_reg <= pwdata[`HWWD_CORE_STKFULL];
                    end
                    default: ;
                endcase
            end
            // Key reset sets flag; set wins over clear
            if (keyResetPend_reg && sresetCnt_reg == SRESET_CYC - 16'h0001)
                rstFlags_reg[`HWWD_RF_KEY] <= 1'b1;
        end
    end

    // Zero-wait APB answer; unmapped reads return zero with no error
    always @(posedge clk)
    begin
        if (rst)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    `HWWD_ADDR_WDCTRL: prdata <= {24'h00_0000, wdCtrl_reg};
                    `HWWD_ADDR_RSTFLAGS: prdata <= {24'h00_0000, rstFlags_reg};
                    `HWWD_ADDR_SYSCLK: prdata <= {30'h0000_0000, sysClockCtrl_reg};
                    `HWWD_ADDR_STATUS: prdata <= {30'h0000_0000, timeoutFlag_reg,
                        powerdownFlag_reg};
                    `HWWD_ADDR_WAKEEN: prdata <= {{(32-PORTW){1'b0}}, portaWakeEnable_reg};
                    `HWWD_ADDR_CORE: prdata <= {30'h0000_0000, stackFull_reg, intEnable_reg};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // hwwd_top
`default_nettype wire

// file: bench/hwwd_monitor.sv
// Checker for the halt, wake-up and watchdog block
`timescale 1ns/1ns
`default_nettype none
`include "hwwd_defs.vh"
module hwwd_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic haltInstr,
    input wire logic internalRcStableFlag,
    input wire logic [2:0] opMode,
    input wire logic hsClockEn,
    input wire logic subClockEn,
    input wire logic cpuRun,
    input wire logic wakeResume,
    input wire logic wakeTakeInt,
    input wire logic pcSpReset,
    input wire logic deviceReset
);
    // ---------------------------------------------
    // Properties, all on the one clock domain
    // ---------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_HALT_STOPS_CORE:
        assert property (haltInstr && cpuRun && opMode == `HWWD_MODE_FAST |=> !cpuRun
            && opMode != `HWWD_MODE_FAST) else $error("halt left the core running");
    AST_IDLE0_CLOCKS:
        assert property (opMode == `HWWD_MODE_IDLE0 |-> !hsClockEn && subClockEn && !cpuRun)
            else $error("idle0 clock gating wrong");
    AST_IDLE1_CLOCKS:
        assert property (opMode == `HWWD_MODE_IDLE1 |-> hsClockEn && subClockEn && !cpuRun)
            else $error("idle1 clock gating wrong");
    AST_IDLE2_CLOCKS:
        assert property (opMode == `HWWD_MODE_IDLE2 |-> hsClockEn && !subClockEn && !cpuRun)
            else $error("idle2 clock gating wrong");
    AST_SLEEP_CLOCKS:
        assert property (opMode == `HWWD_MODE_SLEEP && $past(opMode) != `HWWD_MODE_SLEEP
            |-> !hsClockEn && !subClockEn && !cpuRun) else $error("sleep clock gating wrong");
    // Clocks return in sleep only with a wake pulse; they stay on while the RC settles
    AST_SLEEP_CLOCKS_HELD:
        assert property (opMode == `HWWD_MODE_SLEEP && $rose(hsClockEn)
            |-> wakeResume || wakeTakeInt || pcSpReset)
            else $error("clock woke without a cause");
    // Only one kind of wake or reset response per event
    AST_ONE_RESPONSE:
        assert property ($onehot0({wakeResume, wakeTakeInt, pcSpReset, deviceReset}))
            else $error("two wake responses at once");
    AST_TIMEOUT_ONLY_ASLEEP:
        assert property (pcSpReset |-> !$past(cpuRun)
            && (cpuRun || opMode == `HWWD_MODE_SLEEP))
            else $error("counter reset pulse while running");
    // Synchroniser needs three low samples before it is safe to demand a hold
    AST_RC_STABLE_WAIT:
        assert property ((!internalRcStableFlag)[*3] ##0 opMode == `HWWD_MODE_SLEEP |=> !cpuRun)
            else $error("core woke before the oscillator was stable");
    AST_APB_ZERO_WAIT:
        assert property (psel && !penable |=> pready && !pslverr)
            else $error("bus answer late or erroneous");
endmodule // hwwd_monitor

bind hwwd_top hwwd_monitor mon (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .haltInstr(haltInstr),
    .internalRcStableFlag(internalRcStableFlag), .opMode(opMode), .hsClockEn(hsClockEn),
    .subClockEn(subClockEn), .cpuRun(cpuRun), .wakeResume(wakeResume),
    .wakeTakeInt(wakeTakeInt), .pcSpReset(pcSpReset), .deviceReset(deviceReset));
`default_nettype wire

// file: bench/hwwd_core_model.sv
// Processor core model issuing halt and watchdog-clear instructions
`timescale 1ns/1ns
`default_nettype none
module hwwd_core_model #(
    parameter CLR_GAP = 300
) (
    input wire logic clk,
    input wire logic autoClear,
    output var logic haltInstr,
    output var logic clearWatchdogInstruction
);
    // ---------------------------------------------
    // Instruction strobes
    // ---------------------------------------------
    int gapCnt = 0;
    logic clearNow = 1'b0;

    initial haltInstr = 1'b0;
    initial clearWatchdogInstruction = 1'b0;

    // One-cycle halt; the bench only calls it while the core runs
    task issue_halt;
        @(posedge clk);
        haltInstr <= 1'b1;
        @(posedge clk);
        haltInstr <= 1'b0;
    endtask

    task issue_clear;
        @(posedge clk);
        clearNow <= 1'b1;
        @(posedge clk);
        clearNow <= 1'b0;
    endtask

    // periodic clear
    // Gap kept well under the shortest time-out so the dog never bites
    always @(posedge clk)
    begin
        gapCnt <= (gapCnt >= CLR_GAP) ? 0 : gapCnt + 1;
        clearWatchdogInstruction <= clearNow || (autoClear && gapCnt == CLR_GAP);
    end
endmodule // hwwd_core_model
`default_nettype wire

// file: bench/halt_wakeup_watchdog_tb.sv
// Self-checking testbench for the halt, wake-up and watchdog block
`timescale 1ns/1ns
`default_nettype none
`include "hwwd_defs.vh"
module halt_wakeup_watchdog_tb;
    // ---------------------------------------------
    // Stimulus, instances and shared tasks
    // ---------------------------------------------
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, portAPins = 8'hFF;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, haltInstr, clrInstr, slowRcTick = 1'b0, rcStable = 1'b1;
    logic intRequest = 1'b0, autoClear = 1'b0, tickOn = 1'b0;
    logic [2:0] opMode;
    logic hsClockEn, subClockEn, slowRcEn, cpuRun, wakeResume, wakeTakeInt, pcSpReset, deviceReset;
    logic [1:0] tickDiv = 2'h0;
    int n_fail = 0, checks_done = 0, cnt;
    wire logic [4:0] ev = {cpuRun, deviceReset, pcSpReset, wakeTakeInt, wakeResume};

    always #20 clk = ~clk;

    // Slow RC strobe: one cycle high out of three, so 256 ticks take 768 cycles
    always @(posedge clk)
    begin
        tickDiv <= (tickDiv == 2'h2) ? 2'h0 : tickDiv + 2'h1;
        slowRcTick <= tickOn && tickDiv == 2'h0;
    end

    hwwd_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .haltInstr(haltInstr), .clearWatchdogInstruction(clrInstr), .slowRcTick(slowRcTick),
        .internalRcStableFlag(rcStable), .portAPins(portAPins), .intRequest(intRequest),
        .opMode(opMode), .hsClockEn(hsClockEn), .subClockEn(subClockEn), .slowRcEn(slowRcEn),
        .cpuRun(cpuRun), .wakeResume(wakeResume), .wakeTakeInt(wakeTakeInt),
        .pcSpReset(pcSpReset), .deviceReset(deviceReset));
    hwwd_core_model core (.clk(clk), .autoClear(autoClear), .haltInstr(haltInstr),
        .clearWatchdogInstruction(clrInstr));

    task give_verdict;
        $display("Comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    // Request held until pready is sampled high; answer taken at that edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("bus answer", 32'h0000_0001, 32'(pready));
        if (n >= 16)
            give_verdict();
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask

    // Counts edges until an event; must=0 demands that it does not come within lim edges
    task wait_ev(input int b, input int lim, input bit must);
        cnt = 0;
        while (ev[b] !== 1'b1 && cnt < lim)
        begin
            @(posedge clk);
            cnt++;
        end
        chk("event wait", must ? 32'h0000_0001 : 32'h0000_0000, 32'(cnt < lim));
        if (must && cnt >= lim)
            give_verdict();
    endtask

    task pin_wake(input int b);
        portAPins <= 8'hFE;
        wait_ev(b, 60, 1'b1);
        portAPins <= 8'hFF;
    endtask

    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task t_regs;
        rd_chk(`HWWD_ADDR_WDCTRL, 32'h0000_0053, "wd control reset");
        rd_chk(`HWWD_ADDR_STATUS, 32'h0000_0000, "status reset");
        apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
        rd_chk(8'h1C, 32'h0000_0000, "unmapped read");
    endtask

    task t_modes;
        logic [1:0] s;
        logic [2:0] m;
        apb(1'b1, `HWWD_ADDR_WAKEEN, 32'h0000_0001);
        for (int i = 0; i < 4; i++)
        begin
            s = 2'(3 - i);
            m = s == 2'b01 ? `HWWD_MODE_IDLE0 : s == 2'b11 ? `HWWD_MODE_IDLE1 :
                s == 2'b10 ? `HWWD_MODE_IDLE2 : `HWWD_MODE_SLEEP;
            apb(1'b1, `HWWD_ADDR_SYSCLK, 32'(s));
            core.issue_halt();
            @(posedge clk);
            chk("mode", 32'(m), 32'(opMode));
            chk("clocks", 32'({s, 1'b0}), 32'({hsClockEn, subClockEn, cpuRun}));
            rd_chk(`HWWD_ADDR_STATUS, 32'h0000_0001, "status asleep");
            rcStable <= (s != 2'b00);
            portAPins <= 8'hFD;
            wait_ev(4, 12, 1'b0);
            pin_wake(0);
            if (s == 2'b00)
            begin
                wait_ev(4, 8, 1'b0);
                rcStable <= 1'b1;
                wait_ev(4, 8, 1'b1);
            end
            chk("awake mode", 32'(`HWWD_MODE_FAST), 32'(opMode));
            core.issue_clear();
            rd_chk(`HWWD_ADDR_STATUS, 32'h0000_0000, "status after clear");
        end
    endtask

    task t_ints;
        apb(1'b1, `HWWD_ADDR_SYSCLK, 32'h0000_0003);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, `HWWD_ADDR_CORE, i == 0 ? 32'h0000_0001 : i == 1 ? 32'h0 : 32'h0000_0003);
            core.issue_halt();
            repeat (2) @(posedge clk);
            intRequest <= 1'b1;
            wait_ev(i == 0 ? 1 : 0, 20, 1'b1);
            intRequest <= 1'b0;
        end
        apb(1'b1, `HWWD_ADDR_CORE, 32'h0000_0001);
        intRequest <= 1'b1;
        core.issue_halt();
        @(posedge clk);
        wait_ev(4, 30, 1'b0);
        pin_wake(0);
        intRequest <= 1'b0;
    endtask

    task t_wdt;
        tickOn <= 1'b1;
        apb(1'b1, `HWWD_ADDR_WDCTRL, 32'h0000_0050);
        // Awake bite first, so the timeout flag starts from zero
        core.issue_clear();
        wait_ev(3, 1000, 1'b1);
        rd_chk(`HWWD_ADDR_STATUS, 32'h0000_0002, "timeout flag awake");
        core.issue_halt();
        wait_ev(2, 1000, 1'b1);
        chk("sleep bite time", 32'h0000_0001, 32'(cnt > 700));
        rd_chk(`HWWD_ADDR_STATUS, 32'h0000_0003, "status after sleep bite");
        apb(1'b1, `HWWD_ADDR_WDCTRL, 32'h0000_0050);
        apb(1'b1, `HWWD_ADDR_SYSCLK, 32'h0000_0003);
        autoClear <= 1'b1;
        wait_ev(3, 2000, 1'b0);
        autoClear <= 1'b0;
        core.issue_halt();
        rd_chk(`HWWD_ADDR_STATUS, 32'h0000_0001, "status after halt");
        pin_wake(0);
    endtask

    task t_key;
        apb(1'b1, `HWWD_ADDR_WDCTRL, 32'h0000_0000);
        wait_ev(3, 40, 1'b1);
        chk("reset delay", 32'h0000_0001,
            32'(cnt >= `HWWD_SRESET_CYC - 2 && cnt <= `HWWD_SRESET_CYC + 1));
        apb(1'b1, `HWWD_ADDR_WDCTRL, 32'h0000_00A8);
        wait_ev(3, 40, 1'b1); // re-armed while the bad key still stood
        rd_chk(`HWWD_ADDR_RSTFLAGS, 32'h0000_0001, "key flag set");
        apb(1'b1, `HWWD_ADDR_RSTFLAGS, 32'h0000_0001);
        rd_chk(`HWWD_ADDR_RSTFLAGS, 32'h0000_0001, "key flag kept");
        apb(1'b1, `HWWD_ADDR_RSTFLAGS, 32'h0000_0000);
        rd_chk(`HWWD_ADDR_RSTFLAGS, 32'h0000_0000, "key flag cleared");
        rd_chk(`HWWD_ADDR_WDCTRL, 32'h0000_00A8, "wd control disabled");
        wait_ev(3, 1500, 1'b0);
        apb(1'b1, `HWWD_ADDR_SYSCLK, 32'h0000_0000);
        core.issue_halt();
        @(posedge clk);
        chk("slow clock off", 32'h0000_0000, 32'(slowRcEn));
        pin_wake(4);
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_modes();
        t_ints();
        t_wdt();
        t_key();
        give_verdict();
    end
endmodule // halt_wakeup_watchdog_tb
`default_nettype wire
